//--- hw/adcps_top.sv
// Parallel result port and conversion sequencer of a sampling converter.
`timescale 1ns/1ns
`include "adcps_defs.svh"
//
// Contract
// - First read waits on busy until conversion ends.
// - High-byte read completes with no wait.
// - Read starts conversion, returns previous result.
// - Read after completion returns fresh result, restarts.
// - Start only when all three low; no restart.
// - Busy low throughout conversion, high after.
// - High-byte read: no start, four MSBs low lines.

module adcps_top #(
	parameter int CONV_CYCLES = `ADCPS_CONV_CYCLES	// Conversion length in clock cycles.
) (
	input  wire logic                    CLOCK,            // System clock, 100 MHz.
	input  wire logic                    RST,              // Synchronous reset, active high.
	input  wire logic                    CS_N,             // Device select pin, active low.
	input  wire logic                    RD_N,             // Read strobe pin, active low.
	input  wire logic                    HIGH_BYTE_SELECT, // High byte select pin.
	input  wire logic [`ADCPS_RES_W-1:0] CONV_RESULT,      // Result from the converter core.
	output logic      [`ADCPS_RES_W-1:0] D_OUT,            // Data bus output value.
	output logic      [`ADCPS_RES_W-1:0] D_OE,             // Data bus output enables.
	output logic                         BUSY_N,           // Low while converting.
	output logic                         CHANNEL_ADVANCE,  // Pulse when a sample is taken.
	output logic                         RESULT_VALID,     // Result stream word valid.
	output logic      [`ADCPS_RES_W-1:0] RESULT_DATA,      // Result stream word.
	input  wire logic                    RESULT_READY      // Result stream sink ready.
);

	// -------------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------------
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic       cs_s;
	logic       rd_s;
	logic       hbs_s;

	// The strobes come from the host's domain, so each passes two flip-flops.
	// Both stages reset to the idle-high level, so no false strobe follows reset.
	// The price is two cycles of latency from pin to start decision.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
		end else begin
			pin_meta <= {HIGH_BYTE_SELECT, RD_N, CS_N};
			pin_sync <= pin_meta;
		end
	end

	assign cs_s  = pin_sync[0];
	assign rd_s  = pin_sync[1];
	assign hbs_s = pin_sync[2];

	// -------------------------------------------------------------------------
	// Conversion sequencer
	// -------------------------------------------------------------------------
	// One conversion per access: the host must lift a strobe before the next.
	// The counter is wider than any sensible conversion length needs.
	adcps_pkg::adcps_state_t state;
	adcps_pkg::adcps_state_t next_state;
	logic [15:0]             count;
	logic [15:0]             next_count;
	logic                    armed;
	logic                    next_armed;
	logic                    next_busy_n;
	logic                    next_advance;
	logic [`ADCPS_RES_W-1:0] latch;
	logic [`ADCPS_RES_W-1:0] next_latch;
	logic                    start_req;
	logic                    push;
	logic                    buf_space;

	// A start needs all three inputs low and a fresh access; a held strobe
	// must not retrigger, so the request re-arms only when the read ends.
	assign start_req = ~cs_s & ~rd_s & ~hbs_s & armed;

	// Next-state logic for the sequencer and the output latch.
	always_comb begin
		next_state   = state;
		next_count   = count;
		next_armed   = armed;
		next_busy_n  = BUSY_N;
		next_advance = 1'b0;
		next_latch   = latch;
		push         = 1'b0;
		if (cs_s | rd_s) begin
			next_armed = 1'b1;
		end
		unique case (state)
			adcps_pkg::ADCPS_IDLE: begin
				// Starting only with buffer room means the finished word is never dropped.
				if (start_req && buf_space) begin
					next_state   = adcps_pkg::ADCPS_CONVERT;
					next_count   = 16'h0000;
					next_armed   = 1'b0;
					next_busy_n  = 1'b0;
					next_advance = 1'b1;
				end
			end
			adcps_pkg::ADCPS_CONVERT: begin
				// Further start requests are ignored here.
				next_count = count + 16'h0001;
				if (count == 16'(CONV_CYCLES - 1)) begin
					next_state  = adcps_pkg::ADCPS_IDLE;
					next_busy_n = 1'b1;
					next_latch  = CONV_RESULT;
					push        = 1'b1;
				end
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state           <= adcps_pkg::ADCPS_IDLE;
			count           <= 16'h0000;
			armed           <= 1'b0;
			BUSY_N          <= 1'b1;
			CHANNEL_ADVANCE <= 1'b0;
			latch           <= `ADCPS_RESULT_RESET;
		end else begin
			state           <= next_state;
			count           <= next_count;
			armed           <= next_armed;
			BUSY_N          <= next_busy_n;
			CHANNEL_ADVANCE <= next_advance;
			latch           <= next_latch;
		end
	end

	// -------------------------------------------------------------------------
	// Data bus drivers
	// -------------------------------------------------------------------------
	logic [`ADCPS_RES_W-1:0] next_dout;
	logic [`ADCPS_RES_W-1:0] next_oe;

	// The old latch is shown until the end of conversion, then the new word.
	// The enables follow only the strobes, so a high-byte read drives the bus too.
	// A high-byte read folds the four MSBs onto the low lines, middle nibble low, top nibble kept.
	always_comb begin
		next_oe = {`ADCPS_RES_W{~cs_s & ~rd_s}};
		if (hbs_s) begin
			next_dout = {latch[`ADCPS_HI_MSB:`ADCPS_HI_LSB], 4'h0,
				latch[`ADCPS_HI_MSB:`ADCPS_HI_LSB]};
		end else begin
			next_dout = latch;
		end
	end

	// Data bus registers.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			D_OUT <= `ADCPS_RESULT_RESET;
			D_OE  <= 12'h000;
		end else begin
			D_OUT <= next_dout;
			D_OE  <= next_oe;
		end
	end

	// -------------------------------------------------------------------------
	// Two-entry result buffer
	// -------------------------------------------------------------------------
	logic                    tail_valid;
	logic [`ADCPS_RES_W-1:0] tail;
	logic                    next_head_valid;
	logic [`ADCPS_RES_W-1:0] next_head;
	logic                    next_tail_valid;
	logic [`ADCPS_RES_W-1:0] next_tail;
	logic                    pop;

	// The head entry is the output register; the tail is the spare slot.
	// A full buffer holds off the next conversion rather than losing a word.
	// A word is pushed only at the end of a conversion, and the start gate
	// demands an empty tail, so the push always finds a free slot.
	assign buf_space = ~tail_valid;
	assign pop       = RESULT_VALID & RESULT_READY;

	// Next values for the buffer entries.
	always_comb begin
		next_head_valid = RESULT_VALID;
		next_head       = RESULT_DATA;
		next_tail_valid = tail_valid;
		next_tail       = tail;
		if (pop) begin
			next_head_valid = tail_valid;
			next_head       = tail;
			next_tail_valid = 1'b0;
		end
		if (push) begin
			if (next_head_valid) begin
				next_tail_valid = 1'b1;
				next_tail       = CONV_RESULT;
			end else begin
				next_head_valid = 1'b1;
				next_head       = CONV_RESULT;
			end
		end
	end

	// Buffer registers.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RESULT_VALID <= 1'b0;
			RESULT_DATA  <= `ADCPS_RESULT_RESET;
			tail_valid   <= 1'b0;
			tail         <= `ADCPS_RESULT_RESET;
		end else begin
			RESULT_VALID <= next_head_valid;
			RESULT_DATA  <= next_head;
			tail_valid   <= next_tail_valid;
			tail         <= next_tail;
		end
	end

endmodule

//--- hw/adcps_defs.svh
// Constants for the converter parallel read sequencer.
`ifndef ADCPS_DEFS_SVH
`define ADCPS_DEFS_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define ADCPS_CLK_PERIOD_NS 10
`define ADCPS_CONV_TIME_NS  6000
`define ADCPS_CONV_CYCLES   ((`ADCPS_CONV_TIME_NS + `ADCPS_CLK_PERIOD_NS - 1) / `ADCPS_CLK_PERIOD_NS)

// -----------------------------------------------------------------------------
// Data layout and reset values
// -----------------------------------------------------------------------------
`define ADCPS_RES_W         12
`define ADCPS_HI_MSB        11
`define ADCPS_HI_LSB        8
`define ADCPS_RESULT_RESET  12'h000

`endif

//--- hw/adcps_pkg.sv
// Types shared by the converter parallel read sequencer.
package adcps_pkg;

	// Conversion sequencer states, one-hot.
	typedef enum logic [1:0] {
		ADCPS_IDLE    = 2'b01,
		ADCPS_CONVERT = 2'b10
	} adcps_state_t;

endpackage

//--- verif/adcps_properties.sv
// Port assertions for the read sequencer.
`timescale 1ns/1ns
module adcps_checker #(
	parameter int CONV_CYCLES = 8	// Conversion cycles.
) (
	input wire logic        CLOCK,            // System clock.
	input wire logic        RST,              // Synchronous reset, active high.
	input wire logic        CS_N,             // Device select pin.
	input wire logic        RD_N,             // Read strobe pin.
	input wire logic        HIGH_BYTE_SELECT, // High byte select pin.
	input wire logic        BUSY_N,           // Busy output.
	input wire logic        CHANNEL_ADVANCE,  // Sample pulse.
	input wire logic        RESULT_VALID,     // Stream valid.
	input wire logic        RESULT_READY,     // Stream ready.
	input wire logic [11:0] CONV_RESULT,      // Core result.
	input wire logic [11:0] D_OUT,            // Data bus value.
	input wire logic [11:0] D_OE,             // Data bus enables.
	input wire logic [11:0] RESULT_DATA       // Stream word.
);
	int n, next_n;
	// A counter measures busy, since a repetition cannot span a real conversion.
	always_comb next_n = (RST || BUSY_N) ? 0 : n + 1;
	always_ff @(posedge CLOCK) n <= next_n;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	sequence rd_s; $fell(RD_N) && !CS_N && BUSY_N; endsequence
	sequence hb_s; HIGH_BYTE_SELECT[*5] ##0 D_OE[0]; endsequence
	busy_len_a: assert property ($rose(BUSY_N) |-> n == CONV_CYCLES) else $error("len");
	start_pulse_a: assert property (CHANNEL_ADVANCE == $fell(BUSY_N)) else $error("pls");
	start_cause_a: assert property ($fell(BUSY_N) |-> !$past(CS_N, 3) && !$past(RD_N, 3)
		&& !$past(HIGH_BYTE_SELECT, 3)) else $error("cause");
	start_react_a: assert property (rd_s ##0 (!HIGH_BYTE_SELECT && !RESULT_VALID)
		|-> ##[3:4] $fell(BUSY_N)) else $error("start");
	hb_nowait_a: assert property (rd_s ##0 HIGH_BYTE_SELECT |-> BUSY_N[*6]) else $error("hb");
	hb_layout_a: assert property (hb_s |-> D_OUT[7:4] == 4'h0 && D_OUT[3:0] == D_OUT[11:8])
		else $error("hbl");
	fresh_data_a: assert property ($rose(BUSY_N) |=> D_OUT == $past(CONV_RESULT, 2))
		else $error("new");
	stream_hold_a: assert property (RESULT_VALID && !RESULT_READY |=> RESULT_VALID
		&& $stable(RESULT_DATA)) else $error("hold");
endmodule

//--- verif/adcps_core_model.sv
// Converter core and result sink model.
`timescale 1ns/1ns
module adcps_core_model (
	input wire logic        CLOCK,           // System clock.
	input wire logic        stall,           // Hold the sink off.
	input wire logic        RESULT_VALID,    // Stream valid.
	input wire logic        CHANNEL_ADVANCE, // Sample pulse.
	input wire logic [11:0] level,           // Input level.
	input wire logic [11:0] RESULT_DATA,     // Stream word.
	output logic     [11:0] CONV_RESULT,     // Core result.
	output logic            RESULT_READY     // Sink ready.
);
	int          chan = 0, n = 0;
	logic [11:0] last;
	// Random stalls make the buffer hold words; chan is the channel counter.
	always_ff @(posedge CLOCK) begin
		CONV_RESULT <= level;
		RESULT_READY <= !stall && 1'($urandom_range(1));
		if (CHANNEL_ADVANCE) chan <= chan + 1;
		if (RESULT_VALID && RESULT_READY) begin
			n <= n + 1;
			last <= RESULT_DATA;
		end
	end
endmodule

//--- verif/adc_parallel_read_sequencer_test.sv
// Self-checking bench for the read sequencer.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: %h", $time, a); end end
module adc_parallel_read_sequencer_test;
	logic        clock = 0, rst = 1, cs_n = 1, rd_n = 1, high_byte_select = 0, stall = 0;
	logic        busy_n, adv, rv, rr;
	logic [11:0] level = 12'h000, conv, d_out, d_oe, rdata, v, prev = 12'h000;
	int          err_count = 0, cmp_count = 0, starts = 0;
	adcps_top #(.CONV_CYCLES(8)) DUT (.CLOCK(clock), .RST(rst), .CS_N(cs_n), .RD_N(rd_n),
		.HIGH_BYTE_SELECT(high_byte_select), .CONV_RESULT(conv), .D_OUT(d_out), .D_OE(d_oe),
		.BUSY_N(busy_n), .CHANNEL_ADVANCE(adv), .RESULT_VALID(rv), .RESULT_DATA(rdata),
		.RESULT_READY(rr));
	adcps_core_model P (.CLOCK(clock), .stall(stall), .RESULT_VALID(rv), .CHANNEL_ADVANCE(adv),
		.level(level), .RESULT_DATA(rdata), .CONV_RESULT(conv), .RESULT_READY(rr));
	initial forever #5 clock = ~clock;
	// Expected high-byte read: four MSBs on both top and low nibbles, middle nibble low.
	function automatic logic [11:0] hb_exp(input logic [11:0] w);
		return {w[11:8], 4'h0, w[11:8]};
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One host read; a waiting host holds the strobes while busy is low.
	task automatic rd(input logic hb, input logic hold, input logic [11:0] exp);
		high_byte_select = hb;
		cs_n = 0;
		rd_n = 0;
		starts += 32'(!hb);
		cyc(5);
		for (int i = 0; i < 40 && hold && busy_n !== 1'b1; i++) cyc(1);
		if (hold && busy_n !== 1'b1) begin
			err_count++;
			conclude();
		end
		cyc(2);
		`CHK(d_out, exp)
		`CHK(d_oe, 12'hFFF)
		cs_n = 1;
		rd_n = 1;
		high_byte_select = 0;
		cyc(12);
		`CHK(d_oe, 12'h000)
	endtask
	initial begin
		void'($urandom(32'h90B0C492));
		cyc(10);
		rst = 0;
		// Waiting two-byte reads first, then non-stalling reads; all-zero and all-one lead.
		for (int i = 0; i < 30; i++) begin
			v = (i < 2) ? {12{i[0]}} : 12'($urandom);
			level = v;
			if (i < 15) begin
				rd(0, 1, v);
				rd(1, 1, hb_exp(v));
			end else
				rd(0, 0, prev);
			prev = v;
		end
		// A stalled sink fills both entries, so a third start must wait for space.
		for (int i = 0; i < 20 && rv !== 1'b0; i++) cyc(1);
		if (rv !== 1'b0) begin
			err_count++;
			conclude();
		end
		stall = 1;
		level = 12'hA5A;
		rd(0, 0, prev);
		rd(0, 0, 12'hA5A);
		cs_n = 0;
		rd_n = 0;
		starts++;
		cyc(6);
		`CHK(busy_n, 1'b1)
		stall = 0;
		for (int i = 0; i < 20 && busy_n !== 1'b0; i++) cyc(1);
		`CHK(busy_n, 1'b0)
		rd_n = 1;
		cs_n = 1;
		for (int i = 0; i < 80 && P.n != starts; i++) cyc(1);
		`CHK(P.chan, starts)
		`CHK(P.n, starts)
		`CHK(P.last, 12'hA5A)
		conclude();
	end
endmodule
bind adcps_top adcps_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (
	.CLOCK(CLOCK),
	.RST(RST),
	.CS_N(CS_N),
	.RD_N(RD_N),
	.HIGH_BYTE_SELECT(HIGH_BYTE_SELECT),
	.BUSY_N(BUSY_N),
	.CHANNEL_ADVANCE(CHANNEL_ADVANCE),
	.RESULT_VALID(RESULT_VALID),
	.RESULT_READY(RESULT_READY),
	.CONV_RESULT(CONV_RESULT),
	.D_OUT(D_OUT),
	.D_OE(D_OE),
	.RESULT_DATA(RESULT_DATA)
);
